/* logic/wgs_top.sv */
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
// Operation
// - Software set of shutdown forces overrides immediately
// - No auto-restart: shutdown holds while bit set
// - Auto-restart clears software shutdown; resume on rise
// - Enabled active-low sources force overrides at once
// - Sources: comparators one, two, cell two, pin
// - Level sensed; only disabling ends active source; here a source going inactive also ends it
// - Separate two-bit overrides for B/D and A/C
// - Codes: one, zero, tri-state, inactive level
// - Every shutdown event sets the interrupt flag
// - No restart until shutdown cause has gone
// - Software clears bit; resume on data rise
// - Software clear ignored while condition present
// - Auto-restart: hardware clears bit when conditions gone
// - Keeps running in sleep on its clock
// - Load bit moves dead counts after fall-rise
// - Load set refused unless already enabled
// - Enable bit 7, three-bit mode encoding
// - Input level readable at bit 5
// - Bits 3..0 invert outputs D, C, B, A
// - Dead band may stretch one extra clock
module wgs_top (
  // Clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 nrst_in,
  // APB slave
  input  wire wgs_pkg::wgs_apb_req_t apb_req_in,
  output logic                      apb_pready_out,
  output logic                      apb_pslverr_out,
  output logic [31:0]               apb_prdata_out,
  // Waveform input and shutdown sources
  input  wire logic                 data_in,
  input  wire wgs_pkg::wgs_sources_t sources_in,
  // Outputs: bit 0 = A .. bit 3 = D
  output logic [3:0]                drive_out,
  output logic [3:0]                drive_oe_n_out,
  output logic                      waveform_irq_flag_out,
  output logic                      dead_load_out
);

  // Register state
  logic                      en_reg;
  logic                      ld_reg;
  wgs_pkg::wgs_mode_t        mode_reg;
  logic [3:0]                invert_reg;
  logic                      shutdown_reg;
  logic                      restart_en_reg;
  logic [1:0]                level_bd_reg;
  logic [1:0]                level_ac_reg;
  logic [3:0]                src_en_reg;
  logic [5:0]                rise_cnt_reg;
  logic [5:0]                fall_cnt_reg;
  logic [5:0]                rise_buf_reg;
  logic [5:0]                fall_buf_reg;
  logic                      flag_reg;
  logic                      hold_reg;
  logic                      data_prev_reg;
  logic                      fall_seen_reg;
  logic [5:0]                dead_reg;
  logic                      phase_reg;

  logic                      wr_en;
  logic                      rd_en;
  logic                      addr_hit;
  logic [7:0]                wbyte;
  logic [3:0]                src_active;
  logic                      ext_active;
  logic                      shutdown_next;
  logic                      data_rise;
  logic                      data_fall;
  logic                      overridden;
  logic [5:0]                dead_target;
  logic                      dead_done;
  logic [3:0]                raw_wave;

  // APB decode; zero wait state
  assign wr_en = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite;
  assign rd_en = apb_req_in.psel & apb_req_in.penable & ~apb_req_in.pwrite;
  assign wbyte = apb_req_in.pwdata[7:0];

  always_comb begin
    addr_hit = 1'b1;
    unique case (apb_req_in.paddr)
      wgs_pkg::OFS_CONTROL_MAIN,
      wgs_pkg::OFS_OUTPUT_INVERT,
      wgs_pkg::OFS_SHUTDOWN_CTRL,
      wgs_pkg::OFS_SHUTDOWN_SRC,
      wgs_pkg::OFS_RISE_DEAD,
      wgs_pkg::OFS_FALL_DEAD,
      wgs_pkg::OFS_FLAG_FOUR: addr_hit = 1'b1;
      default:                addr_hit = 1'b0;
    endcase
  end

  assign apb_pready_out  = apb_req_in.psel & apb_req_in.penable;
  assign apb_pslverr_out = apb_req_in.psel & apb_req_in.penable & ~addr_hit;

  always_comb begin
    apb_prdata_out = 32'h0000_0000;
    if (rd_en) begin
      unique case (apb_req_in.paddr)
        wgs_pkg::OFS_CONTROL_MAIN:
          apb_prdata_out[7:0] = {en_reg, ld_reg, 3'h0, mode_reg};
        wgs_pkg::OFS_OUTPUT_INVERT:
          apb_prdata_out[7:0] = {2'h0, data_in, 1'b0, invert_reg};
        wgs_pkg::OFS_SHUTDOWN_CTRL:
          apb_prdata_out[7:0] = {shutdown_reg, restart_en_reg, level_bd_reg, level_ac_reg, 2'h0};
        wgs_pkg::OFS_SHUTDOWN_SRC:
          apb_prdata_out[7:0] = {4'h0, src_en_reg};
        wgs_pkg::OFS_RISE_DEAD:
          apb_prdata_out[7:0] = {2'h0, rise_cnt_reg};
        wgs_pkg::OFS_FALL_DEAD:
          apb_prdata_out[7:0] = {2'h0, fall_cnt_reg};
        wgs_pkg::OFS_FLAG_FOUR:
          apb_prdata_out[7:0] = {7'h00, flag_reg};
        default:
          apb_prdata_out = 32'h0000_0000;
      endcase
    end
  end

  // Shutdown sources, active low, each gated by its own enable
  assign src_active = ~{sources_in.logic_cell_two_out_n, sources_in.comparator_two_out_n,
                        sources_in.comparator_one_out_n, sources_in.pin_select_input_n};
  assign ext_active = |(src_active & src_en_reg);

  assign data_rise = data_in & ~data_prev_reg;
  assign data_fall = ~data_in & data_prev_reg;

  // Status bit: a live condition wins over any clear
  always_comb begin
    shutdown_next = shutdown_reg;
    if (wr_en && apb_req_in.paddr == wgs_pkg::OFS_SHUTDOWN_CTRL) begin
      if (wbyte[wgs_pkg::SDC_SHUTDOWN_POS]) begin
        shutdown_next = 1'b1;
      end else if (!ext_active) begin
        shutdown_next = 1'b0;
      end
    end else if (restart_en_reg && !ext_active) begin
      shutdown_next = 1'b0;
    end
    if (ext_active) begin
      shutdown_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shutdown_reg <= 1'b0;
    end else begin
      shutdown_reg <= shutdown_next;
    end
  end

  // Shutdown control fields
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      restart_en_reg <= 1'b0;
      level_bd_reg   <= wgs_pkg::LEVEL_RESET;
      level_ac_reg   <= wgs_pkg::LEVEL_RESET;
    end else if (wr_en && apb_req_in.paddr == wgs_pkg::OFS_SHUTDOWN_CTRL) begin
      restart_en_reg <= wbyte[wgs_pkg::SDC_RESTART_POS];
      level_bd_reg   <= wbyte[wgs_pkg::SDC_LSBD_LSB +: 2];
      level_ac_reg   <= wbyte[wgs_pkg::SDC_LSAC_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_en_reg <= wgs_pkg::SRC_RESET;
    end else if (wr_en && apb_req_in.paddr == wgs_pkg::OFS_SHUTDOWN_SRC) begin
      src_en_reg <= wbyte[wgs_pkg::SRC_COUNT-1:0];
    end
  end

  // Outputs stay overridden until the first data rise after the bit clears.
  // Starts in the held state so the overrides apply from reset.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_reg <= 1'b1;
    end else if (shutdown_next) begin
      hold_reg <= 1'b1;
    end else if (data_rise) begin
      hold_reg <= 1'b0;
    end
  end

  // Interrupt flag: write one to clear, a new event wins
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_reg <= 1'b0;
    end else if (shutdown_next && !shutdown_reg) begin
      flag_reg <= 1'b1;
    end else if (wr_en && apb_req_in.paddr == wgs_pkg::OFS_FLAG_FOUR && wbyte[wgs_pkg::FLAG_POS]) begin
      flag_reg <= 1'b0;
    end
  end

  assign waveform_irq_flag_out = flag_reg;

  // Main control
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_reg   <= wgs_pkg::CTL_RESET[wgs_pkg::CTL_EN_POS];
      mode_reg <= wgs_pkg::WGS_MODE_STEER_ASYNC;
    end else if (wr_en && apb_req_in.paddr == wgs_pkg::OFS_CONTROL_MAIN) begin
      en_reg   <= wbyte[wgs_pkg::CTL_EN_POS];
      mode_reg <= wgs_pkg::wgs_mode_t'(wbyte[wgs_pkg::CTL_MODE_LSB +: 3]);
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      invert_reg <= wgs_pkg::INV_RESET;
    end else if (wr_en && apb_req_in.paddr == wgs_pkg::OFS_OUTPUT_INVERT) begin
      invert_reg <= wbyte[3:0];
    end
  end

  // Load request: a set only counts if the module was already enabled
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ld_reg        <= 1'b0;
      fall_seen_reg <= 1'b0;
    end else if (wr_en && apb_req_in.paddr == wgs_pkg::OFS_CONTROL_MAIN
                 && wbyte[wgs_pkg::CTL_LD_POS] && en_reg && !ld_reg) begin
      ld_reg        <= 1'b1;
      fall_seen_reg <= 1'b0;
    end else if (ld_reg && !en_reg) begin
      ld_reg        <= 1'b0;
      fall_seen_reg <= 1'b0;
    end else if (ld_reg && fall_seen_reg && data_rise) begin
      ld_reg        <= 1'b0;
      fall_seen_reg <= 1'b0;
    end else if (ld_reg && data_fall) begin
      fall_seen_reg <= 1'b1;
    end
  end

  assign dead_load_out = ld_reg & fall_seen_reg & data_rise;

  // Dead-band counts and their working buffers
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rise_cnt_reg <= wgs_pkg::DEAD_RESET;
      fall_cnt_reg <= wgs_pkg::DEAD_RESET;
    end else if (wr_en && apb_req_in.paddr == wgs_pkg::OFS_RISE_DEAD) begin
      rise_cnt_reg <= wbyte[5:0];
    end else if (wr_en && apb_req_in.paddr == wgs_pkg::OFS_FALL_DEAD) begin
      fall_cnt_reg <= wbyte[5:0];
    end
  end

  // While disabled the buffers follow the counts directly
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rise_buf_reg <= wgs_pkg::DEAD_RESET;
      fall_buf_reg <= wgs_pkg::DEAD_RESET;
    end else if (!en_reg || dead_load_out) begin
      rise_buf_reg <= rise_cnt_reg;
      fall_buf_reg <= fall_cnt_reg;
    end
  end

  // Edge tracking and push-pull phase
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_prev_reg <= 1'b0;
      phase_reg     <= 1'b0;
    end else begin
      data_prev_reg <= data_in;
      if (data_rise) begin
        phase_reg <= ~phase_reg;
      end
    end
  end

  // Dead band restarts on each data edge; since the data input is only
  // seen at the clock the band may run one period longer than programmed.
  assign dead_target = data_in ? rise_buf_reg : fall_buf_reg;
  assign dead_done   = (dead_reg >= dead_target) && !(data_rise || data_fall);

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dead_reg <= wgs_pkg::DEAD_RESET;
    end else if (data_rise || data_fall) begin
      dead_reg <= 6'h01;
    end else if (dead_reg < dead_target) begin
      dead_reg <= dead_reg + 6'h01;
    end
  end

  // Waveform before polarity, bit 0 = A
  always_comb begin
    raw_wave = 4'h0;
    unique case (mode_reg)
      wgs_pkg::WGS_MODE_STEER_ASYNC,
      wgs_pkg::WGS_MODE_STEER_SYNC: raw_wave = {4{data_in}};
      wgs_pkg::WGS_MODE_FULL_FWD:   raw_wave = {data_in, 1'b0, 1'b0, 1'b1};
      wgs_pkg::WGS_MODE_FULL_REV:   raw_wave = {1'b0, 1'b1, data_in, 1'b0};
      wgs_pkg::WGS_MODE_HALF:       raw_wave = {2'h0, ~data_in & dead_done, data_in & dead_done};
      wgs_pkg::WGS_MODE_PUSH_PULL:  raw_wave = {2'h0, data_in & ~phase_reg, data_in & phase_reg};
      wgs_pkg::WGS_MODE_RSVD_6,
      wgs_pkg::WGS_MODE_RSVD_7:     raw_wave = 4'h0;
    endcase
  end

  // Overrides act straight from the source pins, no clock in the path
  assign overridden = hold_reg | ext_active;

  // Pure logic on the one clock, so it runs in sleep whenever that clock does
  always_comb begin
    logic [1:0] code;
    code           = 2'h0;
    drive_out      = 4'h0;
    drive_oe_n_out = 4'h0;
    for (int i = 0; i < 4; i++) begin
      code = (i % 2 == 1) ? level_bd_reg : level_ac_reg;
      if (overridden) begin
        unique case (code)
          wgs_pkg::OVR_ONE:      drive_out[i] = 1'b1;
          wgs_pkg::OVR_ZERO:     drive_out[i] = 1'b0;
          wgs_pkg::OVR_TRISTATE: drive_oe_n_out[i] = 1'b1;
          wgs_pkg::OVR_INACTIVE: drive_out[i] = invert_reg[i];
        endcase
      end else if (!en_reg) begin
        drive_out[i] = invert_reg[i];
      end else begin
        drive_out[i] = raw_wave[i] ^ invert_reg[i];
      end
    end
  end

  // Checks
  a_sw_set_forces: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (wr_en && apb_req_in.paddr == wgs_pkg::OFS_SHUTDOWN_CTRL && wbyte[wgs_pkg::SDC_SHUTDOWN_POS])
    |=> (shutdown_reg && hold_reg))
    else $error("software shutdown not entered");
  a_hold_persists: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    shutdown_reg |-> overridden)
    else $error("outputs not overridden while shutdown set");
  a_auto_clears: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (shutdown_reg && restart_en_reg && !ext_active && !wr_en) |=> !shutdown_reg)
    else $error("auto-restart did not clear shutdown");
  a_ext_immediate: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    ext_active |-> (overridden ##1 shutdown_reg))
    else $error("external source did not force shutdown");
  a_level_persist: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (ext_active && $stable(src_en_reg)) |=> shutdown_reg)
    else $error("shutdown cleared with source active");
  a_irq_on_event: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(shutdown_reg) |-> flag_reg)
    else $error("shutdown event without flag");
  a_resume_on_rise: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $fell(hold_reg) |-> ($past(data_in) && !$past(data_prev_reg) && !shutdown_reg))
    else $error("resume without data rise");
  a_ld_needs_en: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(ld_reg) |-> $past(en_reg))
    else $error("load accepted while disabled");
  a_ld_transfer: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    dead_load_out |=> (!ld_reg && rise_buf_reg == $past(rise_cnt_reg)))
    else $error("load did not transfer counts");
  a_reserved_idle: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (mode_reg[2:1] == 2'b11 && en_reg && !overridden) |-> (drive_out == invert_reg))
    else $error("reserved mode drove active level");
  a_polarity: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (en_reg && !overridden) |-> ((drive_out ^ invert_reg) == raw_wave))
    else $error("polarity not applied");

endmodule

/* logic/wgs_pkg.sv */
package wgs_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_CONTROL_MAIN  = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_INVERT = 8'h04;
  localparam logic [7:0] OFS_SHUTDOWN_CTRL = 8'h08;
  localparam logic [7:0] OFS_SHUTDOWN_SRC  = 8'h0C;
  localparam logic [7:0] OFS_RISE_DEAD     = 8'h10;
  localparam logic [7:0] OFS_FALL_DEAD     = 8'h14;
  localparam logic [7:0] OFS_FLAG_FOUR     = 8'h18;

  // waveform_control_main fields
  localparam int CTL_EN_POS   = 7;
  localparam int CTL_LD_POS   = 6;
  localparam int CTL_MODE_LSB = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // waveform_output_invert fields
  localparam int INV_IN_POS = 5;
  localparam logic [3:0] INV_RESET = 4'h0;

  // shutdown_control_reg fields
  localparam int SDC_SHUTDOWN_POS = 7;
  localparam int SDC_RESTART_POS  = 6;
  localparam int SDC_LSBD_LSB     = 4;
  localparam int SDC_LSAC_LSB     = 2;
  localparam logic [1:0] LEVEL_RESET = 2'h1;

  // shutdown_source_reg: bit 0 pin select, 1 comparator one, 2 comparator two, 3 logic cell two
  localparam int SRC_COUNT = 4;
  localparam logic [3:0] SRC_RESET = 4'h0;

  // peripheral_flag_reg_four: waveform_irq_flag position
  localparam int FLAG_POS = 0;

  localparam int DEAD_W = 6;
  localparam logic [5:0] DEAD_RESET = 6'h00;

  // Override codes
  localparam logic [1:0] OVR_ONE      = 2'h3;
  localparam logic [1:0] OVR_ZERO     = 2'h2;
  localparam logic [1:0] OVR_TRISTATE = 2'h1;
  localparam logic [1:0] OVR_INACTIVE = 2'h0;

  typedef enum logic [2:0] {
    WGS_MODE_STEER_ASYNC = 3'b000,
    WGS_MODE_STEER_SYNC  = 3'b001,
    WGS_MODE_FULL_FWD    = 3'b010,
    WGS_MODE_FULL_REV    = 3'b011,
    WGS_MODE_HALF        = 3'b100,
    WGS_MODE_PUSH_PULL   = 3'b101,
    WGS_MODE_RSVD_6      = 3'b110,
    WGS_MODE_RSVD_7      = 3'b111
  } wgs_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } wgs_apb_req_t;

  // Active-low external shutdown sources
  typedef struct packed {
    logic logic_cell_two_out_n;
    logic comparator_two_out_n;
    logic comparator_one_out_n;
    logic pin_select_input_n;
  } wgs_sources_t;

endpackage

/* tb/wgs_far_side.sv */
`timescale 1ns/100ps
module wgs_far_side (
  // Clock
  input  wire logic             ref_clk_in,
  // Bench requests
  input  wire logic [3:0]       src_active_in,
  input  wire logic [1:0]       lag_in,
  // Design side
  input  wire logic [3:0]       drive_in,
  input  wire logic [3:0]       drive_oe_n_in,
  output wgs_pkg::wgs_sources_t sources_out,
  output logic [3:0]            pin_level_out
);
  logic [3:0] hist_reg [4];

  // Slow sources trail the request by up to three cycles
  always_ff @(posedge ref_clk_in) begin
    hist_reg <= '{src_active_in, hist_reg[0], hist_reg[1], hist_reg[2]};
  end

  // Sources idle high and pull low when active
  assign sources_out = (lag_in == 2'h0) ? ~src_active_in : ~hist_reg[lag_in - 2'h1];

  // Gate pull-downs on the switch drivers: a released pin reads low
  assign pin_level_out = drive_in & ~drive_oe_n_in;
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  localparam logic [7:0] A_CTL = wgs_pkg::OFS_CONTROL_MAIN;
  localparam logic [7:0] A_INV = wgs_pkg::OFS_OUTPUT_INVERT;
  localparam logic [7:0] A_SDC = wgs_pkg::OFS_SHUTDOWN_CTRL;
  localparam logic [7:0] A_SRC = wgs_pkg::OFS_SHUTDOWN_SRC;
  localparam logic [7:0] A_FLG = wgs_pkg::OFS_FLAG_FOUR;

  logic                  ref_clk;
  logic                  nrst;
  wgs_pkg::wgs_apb_req_t req;
  logic                  pready;
  logic                  pslverr;
  logic [31:0]           prdata;
  logic                  data;
  logic [3:0]            src_act;
  logic [1:0]            lag;
  logic [3:0]            drive;
  logic [3:0]            oe_n;
  logic                  flag;
  logic                  dead_load;
  wgs_pkg::wgs_sources_t sources;
  logic [3:0]            pins;
  logic [31:0]           rd;
  logic                  err;
  int                    n_fail;
  int                    n_compared;
  int                    n_load;
  int                    base;
  logic [3:0]            mode_exp [8] = '{4'hF, 4'hF, 4'h9, 4'h6, 4'h1, 4'h0, 4'h0, 4'h0};

  wgs_top uut (
    .ref_clk_in(ref_clk), .nrst_in(nrst), .apb_req_in(req), .apb_pready_out(pready),
    .apb_pslverr_out(pslverr), .apb_prdata_out(prdata), .data_in(data), .sources_in(sources),
    .drive_out(drive), .drive_oe_n_out(oe_n), .waveform_irq_flag_out(flag), .dead_load_out(dead_load)
  );

  wgs_far_side far (
    .ref_clk_in(ref_clk), .src_active_in(src_act), .lag_in(lag), .drive_in(drive),
    .drive_oe_n_in(oe_n), .sources_out(sources), .pin_level_out(pins)
  );

  always #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (dead_load === 1'b1) n_load++;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares {enables, pin levels} a little after the edge, returns on the next edge
  task automatic chk_pins(input logic [7:0] exp);
    #1;
    chk_val({24'h0, oe_n, pins}, {24'h0, exp});
    @(posedge ref_clk);
  endtask

  // One idle cycle after each transfer keeps the request from being driven twice per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 20) n_fail++;
    rd = prdata;
    err = pslverr;
    req <= '0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_val(rd, exp);
  endtask

  task automatic rise;
    data <= 1'b0;
    repeat (2) @(posedge ref_clk);
    data <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  function automatic logic [7:0] ovr(input logic [1:0] bd, input logic [1:0] ac, input logic [3:0] pol);
    logic [3:0] oe;
    logic [3:0] v;
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = k[0] ? bd : ac;
      oe[k] = (c == wgs_pkg::OVR_TRISTATE);
      v[k] = (c == wgs_pkg::OVR_ONE) | ((c == wgs_pkg::OVR_INACTIVE) & pol[k]);
    end
    return {oe, v};
  endfunction

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    test_done();
  end

  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    req = '0;
    data = 1'b0;
    src_act = 4'h0;
    lag = 2'h0;
    n_fail = 0;
    n_compared = 0;
    n_load = 0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk_pins(8'hF0);
    rchk(A_CTL, 32'h0);
    rchk(A_SDC, 32'h14);
    chk_val({31'h0, flag}, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk_val({err, rd[30:0]}, 32'h8000_0000);
    data <= 1'b1;
    rchk(A_INV, 32'h20);
    data <= 1'b0;
    rchk(A_INV, 32'h0);
    $display("test reset done");

    // Overrides are programmed before enabling, start-up is from shutdown
    wr(A_INV, 32'h3);
    wr(A_SDC, 32'hB8);
    wr(A_CTL, 32'h80);
    chk_pins(8'h0A);
    wr(A_SDC, 32'h38);
    chk_pins(8'h0A);
    rise();
    chk_pins(8'h0C);
    $display("test start done");

    wr(A_FLG, 32'h1);
    rchk(A_FLG, 32'h0);
    wr(A_SDC, 32'hB8);
    chk_pins(8'h0A);
    chk_val({31'h0, flag}, 32'h1);
    rise();
    rise();
    rchk(A_SDC, 32'hB8);
    chk_pins(8'h0A);
    for (int c = 0; c < 4; c++) begin
      wr(A_SDC, {24'h0, 2'b10, 2'(c), 2'(3 - c), 2'b00});
      chk_pins(ovr(2'(c), 2'(3 - c), 4'h3));
    end
    wr(A_SDC, 32'h38);
    rise();
    chk_pins(8'h0C);
    $display("test software shutdown done");

    wr(A_FLG, 32'h1);
    wr(A_SDC, 32'hF8);
    chk_pins(8'h0A);
    rchk(A_SDC, 32'h78);
    chk_val({31'h0, flag}, 32'h1);
    rise();
    chk_pins(8'h0C);
    wr(A_SDC, 32'h38);
    wr(A_FLG, 32'h1);
    $display("test auto restart done");

    src_act <= 4'hF;
    chk_pins(8'h0C);
    src_act <= 4'h0;
    for (int i = 0; i < 4; i++) begin
      wr(A_SRC, 32'h1 << i);
      lag <= 2'(i);
      src_act <= 4'h1 << i;
      repeat (i) @(posedge ref_clk);
      chk_pins(8'h0A);
      rchk(A_SDC, 32'hB8);
      chk_val({31'h0, flag}, 32'h1);
      wr(A_SDC, 32'h38);
      rchk(A_SDC, 32'hB8);
      rise();
      chk_pins(8'h0A);
      if (i[0]) begin
        wr(A_SRC, 32'h0);
      end else begin
        src_act <= 4'h0;
      end
      rise();
      chk_pins(8'h0A);
      wr(A_SDC, 32'h38);
      rise();
      chk_pins(8'h0C);
      src_act <= 4'h0;
      wr(A_FLG, 32'h1);
    end
    lag <= 2'h0;
    wr(A_SRC, 32'h2);
    wr(A_SDC, 32'h78);
    src_act <= 4'h2;
    rchk(A_SDC, 32'hF8);
    src_act <= 4'h0;
    rchk(A_SDC, 32'h78);
    rise();
    chk_pins(8'h0C);
    wr(A_SDC, 32'h38);
    $display("test external sources done");

    wr(A_INV, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wr(A_CTL, 32'h80 | m);
      rise();
      // Push-pull swaps A and B each period, so compare two periods
      if (m == 5) begin
        #1;
        rd = {28'h0, pins};
        @(posedge ref_clk);
        rise();
        #1;
        chk_val({28'h0, pins} ^ rd, 32'h3);
        @(posedge ref_clk);
      end else begin
        chk_pins({4'h0, mode_exp[m]});
      end
    end
    $display("test modes done");

    wr(A_CTL, 32'h80);
    wr(wgs_pkg::OFS_RISE_DEAD, 32'h5);
    wr(A_CTL, 32'hC0);
    rchk(A_CTL, 32'hC0);
    base = n_load;
    data <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_val(32'(n_load - base), 32'h0);
    data <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_val(32'(n_load - base), 32'h1);
    rchk(A_CTL, 32'h80);
    wr(A_CTL, 32'h0);
    wr(A_CTL, 32'hC0);
    rchk(A_CTL, 32'h80);
    $display("test load done");
    test_done();
  end
endmodule
